// File: ckpll_pkg.sv
// Package with register map, field positions, reset values and timing counts for the clock block.
package ckpll_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] CKPLL_IDX_CLK_CTRL = 10'h08f;
    localparam logic [9:0] CKPLL_IDX_SYN_CTRL = 10'h0e9;
    localparam logic [9:0] CKPLL_IDX_REF_DIV = 10'h0ee;
    localparam logic [9:0] CKPLL_IDX_FB_DIV_HI = 10'h0ef;
    localparam logic [9:0] CKPLL_IDX_IRQ_STAT = 10'h0f0;
    localparam logic [9:0] CKPLL_IDX_IRQ_MASK = 10'h0f1;
    // Clock control fields.
    localparam int CKPLL_CK_DOUBLE = 0;
    localparam int CKPLL_CK_T0SEL = 1;
    localparam int CKPLL_CK_T1SEL = 2;
    localparam int CKPLL_CK_WDSEL = 6;
    localparam logic [7:0] CKPLL_CK_WMASK = 8'h47;
    // Synth control fields.
    localparam int CKPLL_SY_LOCK = 0;
    localparam int CKPLL_SY_EN = 1;
    localparam int CKPLL_SY_RST = 3;
    localparam logic [7:0] CKPLL_SY_WMASK = 8'hca;
    localparam logic [7:0] CKPLL_SY_RESET = 8'h08;
    localparam logic [7:0] CKPLL_REF_WMASK = 8'h7f;
    localparam logic [7:0] CKPLL_DIV_RESET = 8'h00;
    // Interrupt status fields.
    localparam int CKPLL_IRQ_GAIN = 0;
    localparam int CKPLL_IRQ_LOSS = 1;
    localparam logic [1:0] CKPLL_IRQ_RESET = 2'h0;
    // Machine cycle length in CPU clock enables: 12 or 6 oscillator periods.
    localparam logic [2:0] CKPLL_MC_CPU_CLKS = 3'h6;
    // Lock detection: largest phase gap in cycles and good comparisons needed.
    localparam logic [3:0] CKPLL_LOCK_WIN = 4'h2;
    localparam logic [3:0] CKPLL_LOCK_CNT = 4'h8;
    typedef enum logic [1:0] {
        CKPLL_PFD_IDLE,
        CKPLL_PFD_UP,
        CKPLL_PFD_DOWN
    } ckpll_pfd_t;
endpackage : ckpll_pkg

// File: ckpll_ctrl.sv
// Clock controller with speed selection, per-unit clock sources and a digital synthesizer core.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Three gated clocks: synth, CPU, peripheral.
// - Peripheral clock drives timers, card, ADC, SPI, ports.
// - Double speed: 6 periods, else 12.
// - Double speed loads from boot bit, zero on ROM variant.
// - Watchdog source: oscillator half or peripheral.
// - Timer 1 source: oscillator half or peripheral.
// - Timer 0 source: oscillator half or peripheral.
// - Clock control reserved bits; software writes zero.
// - Detector compares reference and feedback edges.
// - Synth enable starts and stops generation.
// - Lock flag follows lock, writes ignored.
// - Synth reset holds synthesizer, set after reset.
// - Feedback divider is ten bits, split.
// - Reference divider seven bits, top reads zero.
// - Synth control reserved bits read zero.
// - Audio and USB clocks from synthesizer.
module ckpll_ctrl (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and power state.
    input wire logic boot_speed_config_bit,
    input wire logic rom_variant,
    input wire logic idle_mode,
    input wire logic power_down,
    // Oscillator clock from the synthesizer's oscillator.
    input wire logic vco_pulse,
    // Clock enables.
    output logic cpu_clk_en,
    output logic per_clk_en,
    output logic machine_cycle,
    output logic timer0_clk_en,
    output logic timer1_clk_en,
    output logic card_clk_en,
    output logic adc_clk_en,
    output logic spi_clk_en,
    output logic port_clk_en,
    output logic wdt_clk_en,
    output logic synth_ref_clk_en,
    output logic audio_clk_en,
    output logic usb_clk_en,
    // Detector and lock.
    output logic pump_up,
    output logic pump_down,
    output logic synth_lock_flag,
    // Interrupt.
    output logic irq
);
    import ckpll_pkg::*;

    function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
        reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Register bus.
    logic [7:0] clock_ctrl_r;
    logic [7:0] synth_ctrl_r;
    logic [7:0] ref_div_r;
    logic [7:0] fb_div_high_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_stat_nxt;
    logic [7:0] synth_rd;
    logic [31:0] prdata_nxt;
    logic lock_r;
    logic lock_gain;
    logic lock_loss;

    wire hit_ck = reg_hit(paddr, CKPLL_IDX_CLK_CTRL);
    wire hit_sy = reg_hit(paddr, CKPLL_IDX_SYN_CTRL);
    wire hit_ref = reg_hit(paddr, CKPLL_IDX_REF_DIV);
    wire hit_fb = reg_hit(paddr, CKPLL_IDX_FB_DIV_HI);
    wire hit_st = reg_hit(paddr, CKPLL_IDX_IRQ_STAT);
    wire hit_mk = reg_hit(paddr, CKPLL_IDX_IRQ_MASK);
    wire hit_any = hit_ck | hit_sy | hit_ref | hit_fb | hit_st | hit_mk;
    wire acc = psel & penable;
    wire wr = acc & pwrite & hit_any;
    // Reserved bits are forced low on write and read; lock bit comes from hardware.
    assign synth_rd = (synth_ctrl_r & CKPLL_SY_WMASK) | {7'h00, lock_r};
    assign prdata_nxt = hit_ck ? {24'h0, clock_ctrl_r & CKPLL_CK_WMASK} :
                        hit_sy ? {24'h0, synth_rd} :
                        hit_ref ? {24'h0, ref_div_r & CKPLL_REF_WMASK} :
                        hit_fb ? {24'h0, fb_div_high_r} :
                        hit_st ? {30'h0, irq_stat_r} :
                        hit_mk ? {30'h0, irq_mask_r} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;
    // Hardware set wins over a write-one clear in the same cycle.
    assign irq_stat_nxt = (irq_stat_r & ~((wr & hit_st) ? pwdata[1:0] : 2'h0))
                        | {lock_loss, lock_gain};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // A synchronous reset may sample the strap on the same edge.
            clock_ctrl_r <= {7'h00, boot_speed_config_bit & ~rom_variant};
            synth_ctrl_r <= CKPLL_SY_RESET;
            ref_div_r <= CKPLL_DIV_RESET;
            fb_div_high_r <= CKPLL_DIV_RESET;
            irq_mask_r <= CKPLL_IRQ_RESET;
            irq_stat_r <= CKPLL_IRQ_RESET;
            prdata <= 32'h0;
        end else begin
            if (wr & hit_ck) begin
                clock_ctrl_r <= pwdata[7:0] & CKPLL_CK_WMASK;
            end
            if (wr & hit_sy) begin
                synth_ctrl_r <= pwdata[7:0] & CKPLL_SY_WMASK;
            end
            if (wr & hit_ref) begin
                ref_div_r <= pwdata[7:0] & CKPLL_REF_WMASK;
            end
            if (wr & hit_fb) begin
                fb_div_high_r <= pwdata[7:0];
            end
            if (wr & hit_mk) begin
                irq_mask_r <= pwdata[1:0];
            end
            irq_stat_r <= irq_stat_nxt;
            // Read data is taken in the setup cycle so that it stands in the access phase.
            if (psel & ~penable & ~pwrite) begin
                prdata <= prdata_nxt;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    //////////////////////////////////////////////////////////////////////////////////////////////
    // System clock enables.
    logic phase_r;
    logic x2_r;
    logic [2:0] mc_cnt_r;
    logic mc_r;
    logic cpu_r;
    logic per_r;
    logic half_r;
    logic t0_r;
    logic t1_r;
    logic wd_r;
    logic ref_on_r;

    wire per_on = ~power_down;
    wire cpu_on = ~power_down & ~idle_mode;
    wire half_tick = phase_r;
    wire sys_tick = x2_r | phase_r;
    wire mc_wrap = (mc_cnt_r == CKPLL_MC_CPU_CLKS - 3'h1);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r <= 1'b0;
            x2_r <= 1'b0;
            mc_cnt_r <= 3'h0;
            mc_r <= 1'b0;
            cpu_r <= 1'b0;
            per_r <= 1'b0;
            half_r <= 1'b0;
            t0_r <= 1'b0;
            t1_r <= 1'b0;
            wd_r <= 1'b0;
            ref_on_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            // Switching only after a half-rate pulse keeps every pulse whole.
            if (phase_r) begin
                x2_r <= clock_ctrl_r[CKPLL_CK_DOUBLE];
            end
            if (sys_tick & cpu_on) begin
                mc_cnt_r <= mc_wrap ? 3'h0 : mc_cnt_r + 3'h1;
            end
            mc_r <= sys_tick & cpu_on & mc_wrap;
            cpu_r <= sys_tick & cpu_on;
            per_r <= sys_tick & per_on;
            half_r <= half_tick & per_on;
            t0_r <= per_on & (clock_ctrl_r[CKPLL_CK_T0SEL] ? half_tick : sys_tick);
            t1_r <= per_on & (clock_ctrl_r[CKPLL_CK_T1SEL] ? half_tick : sys_tick);
            wd_r <= per_on & (clock_ctrl_r[CKPLL_CK_WDSEL] ? half_tick : sys_tick);
            ref_on_r <= per_on;
        end
    end

    assign cpu_clk_en = cpu_r;
    assign per_clk_en = per_r;
    assign machine_cycle = mc_r;
    assign timer0_clk_en = t0_r;
    assign timer1_clk_en = t1_r;
    assign wdt_clk_en = wd_r;
    assign card_clk_en = per_r;
    assign adc_clk_en = per_r;
    assign spi_clk_en = per_r;
    assign port_clk_en = per_r;
    assign synth_ref_clk_en = ref_on_r;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Synthesizer dividers, detector and lock.
    logic [6:0] ref_cnt_r;
    logic [9:0] fb_cnt_r;
    logic ref_tick_r;
    logic fb_tick_r;
    ckpll_pfd_t pfd_r;
    logic [3:0] gap_r;
    logic [3:0] good_r;
    logic out_r;

    wire [9:0] fb_div = {fb_div_high_r, synth_ctrl_r[7:6]};
    wire [6:0] ref_div = ref_div_r[6:0];
    wire run = synth_ctrl_r[CKPLL_SY_EN] & ~synth_ctrl_r[CKPLL_SY_RST]
               & ~power_down;
    wire ref_tick = run & (ref_cnt_r == ref_div);
    wire fb_tick = run & vco_pulse & (fb_cnt_r == fb_div);
    wire gap_ok = (gap_r <= CKPLL_LOCK_WIN);
    wire cmp_done = (pfd_r == CKPLL_PFD_UP & fb_tick) | (pfd_r == CKPLL_PFD_DOWN & ref_tick);
    wire both = ref_tick & fb_tick;
    wire good_done = both | (cmp_done & gap_ok);
    wire bad_done = cmp_done & ~gap_ok;
    wire lock_nxt = run & (lock_r ? ~bad_done : (good_done & good_r == CKPLL_LOCK_CNT - 4'h1));
    assign lock_gain = lock_nxt & ~lock_r;
    assign lock_loss = ~lock_nxt & lock_r;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !run) begin
            ref_cnt_r <= 7'h0;
            fb_cnt_r <= 10'h0;
            pfd_r <= CKPLL_PFD_IDLE;
            gap_r <= 4'h0;
            good_r <= 4'h0;
        end else begin
            ref_cnt_r <= ref_tick ? 7'h0 : ref_cnt_r + 7'h1;
            if (vco_pulse) begin
                fb_cnt_r <= fb_tick ? 10'h0 : fb_cnt_r + 10'h1;
            end
            // Reference first asks for speed, feedback first asks to slow down.
            unique case (pfd_r)
                CKPLL_PFD_IDLE: begin
                    if (ref_tick & ~fb_tick) begin
                        pfd_r <= CKPLL_PFD_UP;
                    end else if (fb_tick & ~ref_tick) begin
                        pfd_r <= CKPLL_PFD_DOWN;
                    end
                end
                CKPLL_PFD_UP: begin
                    if (fb_tick) begin
                        pfd_r <= CKPLL_PFD_IDLE;
                    end
                end
                CKPLL_PFD_DOWN: begin
                    if (ref_tick) begin
                        pfd_r <= CKPLL_PFD_IDLE;
                    end
                end
                default: begin
                    pfd_r <= CKPLL_PFD_IDLE;
                end
            endcase
            if (pfd_r == CKPLL_PFD_IDLE) begin
                gap_r <= 4'h1;
            end else if (gap_r != 4'hf) begin
                gap_r <= gap_r + 4'h1;
            end
            if (bad_done) begin
                good_r <= 4'h0;
            end else if (good_done && good_r != CKPLL_LOCK_CNT - 4'h1) begin
                good_r <= good_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lock_r <= 1'b0;
            out_r <= 1'b0;
            ref_tick_r <= 1'b0;
            fb_tick_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
            out_r <= run & vco_pulse;
            ref_tick_r <= ref_tick;
            fb_tick_r <= fb_tick;
        end
    end

    // Gating on lock is left to software, which polls the flag first.
    assign audio_clk_en = out_r;
    assign usb_clk_en = out_r;
    assign pump_up = (pfd_r == CKPLL_PFD_UP);
    assign pump_down = (pfd_r == CKPLL_PFD_DOWN);
    assign synth_lock_flag = lock_r;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_std_pair;
        rst_n && !x2_r && per_on ##1 !x2_r && per_on;
    endsequence

    std_half_rate_a: assert property (s_std_pair |-> ##1 (per_r != $past(per_r)))
        else $error("Peripheral enable not at half rate in standard speed.");
    x2_full_rate_a: assert property (x2_r && per_on |=> per_r)
        else $error("Peripheral enable missing in double speed.");
    speed_boundary_a: assert property (x2_r != $past(x2_r) |-> $past(phase_r))
        else $error("Speed changed off a clock boundary.");
    cpu_gate_a: assert property (idle_mode |=> !cpu_r)
        else $error("CPU enable active while idle.");
    t0_half_a: assert property (clock_ctrl_r[1] && per_on |=> t0_r == $past(phase_r))
        else $error("Timer 0 not on half oscillator.");
    t1_half_a: assert property (clock_ctrl_r[2] && per_on |=> t1_r == $past(phase_r))
        else $error("Timer 1 not on half oscillator.");
    wd_source_a: assert property (!clock_ctrl_r[6] |=> wd_r == per_r)
        else $error("Watchdog not on peripheral clock.");
    lock_stop_a: assert property (!run |=> !lock_r ##0 !pump_up && !pump_down)
        else $error("Synthesizer active while stopped.");
    reserved_zero_a: assert property (acc && !pwrite && hit_sy |->
        prdata[5:4] == 2'h0 && !prdata[2])
        else $error("Reserved synth bits read as one.");
    // A write-one clear in the cycle after the event may legally drop the flag.
    gain_irq_a: assert property (lock_gain |=> irq_stat_r[CKPLL_IRQ_GAIN] ##1
        (irq_stat_r[CKPLL_IRQ_GAIN] || $past(wr && hit_st && pwdata[CKPLL_IRQ_GAIN])))
        else $error("Lock gain event lost.");
    loss_irq_a: assert property (lock_loss |=> irq_stat_r[CKPLL_IRQ_LOSS])
        else $error("Lock loss event lost.");
    ref_top_zero_a: assert property (acc && !pwrite && hit_ref |-> !prdata[7])
        else $error("Reference divider top bit read as one.");
    audio_stop_a: assert property (!run |=> !audio_clk_en && !usb_clk_en)
        else $error("Synthesizer clock enables active while stopped.");
    pump_start_a: assert property (pfd_r == CKPLL_PFD_IDLE && ref_tick && !fb_tick |=> pump_up)
        else $error("Early reference did not raise the up pump.");
endmodule : ckpll_ctrl

// File: test_clock_and_pll_control.sv
// Self-checking testbench for the clock and synthesizer controller.
`timescale 1ns/10ps
module test_clock_and_pll_control;
    import ckpll_pkg::*;
    typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] q; logic e;} ckpll_row_t;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr;
    logic boot_speed_config_bit = 1'b1, rom_variant = 1'b0, idle_mode = 1'b0;
    logic power_down = 1'b0, vco_pulse = 1'b1;
    logic cpu_clk_en, per_clk_en, machine_cycle, timer0_clk_en, timer1_clk_en, card_clk_en;
    logic adc_clk_en, spi_clk_en, port_clk_en, wdt_clk_en, synth_ref_clk_en, audio_clk_en;
    logic usb_clk_en, pump_up, pump_down, synth_lock_flag, irq;
    int mismatches = 0, checked = 0, n;
    int c[12];
    ckpll_row_t rows[8];
    always #5 clk_sys = ~clk_sys;
    ckpll_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_speed_config_bit(boot_speed_config_bit),
        .rom_variant(rom_variant), .idle_mode(idle_mode), .power_down(power_down),
        .vco_pulse(vco_pulse), .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
        .machine_cycle(machine_cycle), .timer0_clk_en(timer0_clk_en),
        .timer1_clk_en(timer1_clk_en), .card_clk_en(card_clk_en), .adc_clk_en(adc_clk_en),
        .spi_clk_en(spi_clk_en), .port_clk_en(port_clk_en), .wdt_clk_en(wdt_clk_en),
        .synth_ref_clk_en(synth_ref_clk_en), .audio_clk_en(audio_clk_en),
        .usb_clk_en(usb_clk_en), .pump_up(pump_up), .pump_down(pump_down),
        .synth_lock_flag(synth_lock_flag), .irq(irq));
    //////////////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction : ba
    // The master waits on pready itself; the bench timeout is the only bound.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rerr = pslverr;
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic do_reset;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset
    // Counting over whole windows makes the checks independent of divider phase.
    task automatic tally(input int cyc);
        c = '{default: 0};
        repeat (cyc) begin
            @(posedge clk_sys);
            #1;
            c[0] += cpu_clk_en;
            c[1] += per_clk_en;
            c[2] += machine_cycle;
            c[3] += timer0_clk_en;
            c[4] += timer1_clk_en;
            c[5] += wdt_clk_en;
            c[6] += synth_ref_clk_en;
            c[7] += audio_clk_en;
            c[8] += usb_clk_en;
            c[9] += (card_clk_en === per_clk_en && adc_clk_en === per_clk_en &&
                     spi_clk_en === per_clk_en && port_clk_en === per_clk_en);
            c[10] += pump_up;
            c[11] += pump_down;
        end
    endtask : tally
    task automatic speed(input logic [7:0] v, input int pc, input int mc, input int tc);
        apb(1'b1, ba(CKPLL_IDX_CLK_CTRL), v);
        repeat (14) @(posedge clk_sys);
        tally(24);
        chk("per_clk_en", c[1], pc);
        chk("cpu_clk_en", c[0], pc);
        chk("machine_cycle", c[2], mc);
        chk("timer0", c[3], v[1] ? tc : pc);
        chk("timer1", c[4], v[2] ? tc : pc);
        chk("watchdog", c[5], v[6] ? tc : pc);
        chk("shared enables", c[9], 24);
        chk("synth ref", c[6], 24);
    endtask : speed
    //////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
    initial begin
        rows = '{'{ba(CKPLL_IDX_CLK_CTRL), 8'h47, 8'h47, 1'b0},
                 '{ba(CKPLL_IDX_SYN_CTRL), 8'hc9, 8'hc8, 1'b0},
                 '{ba(CKPLL_IDX_REF_DIV), 8'h7f, 8'h7f, 1'b0},
                 '{ba(CKPLL_IDX_FB_DIV_HI), 8'ha5, 8'ha5, 1'b0},
                 '{ba(CKPLL_IDX_IRQ_MASK), 8'h03, 8'h03, 1'b0},
                 '{ba(CKPLL_IDX_IRQ_STAT), 8'h03, 8'h00, 1'b0},
                 '{ba(10'h0f2), 8'h5a, 8'h00, 1'b1},
                 '{12'h23d, 8'h01, 8'h00, 1'b1}};
        do_reset();
        apb(1'b0, ba(CKPLL_IDX_CLK_CTRL), 8'h00);
        chk("boot speed", rdat, 32'h01);
        apb(1'b0, ba(CKPLL_IDX_SYN_CTRL), 8'h00);
        chk("synth reset value", rdat, {24'h0, CKPLL_SY_RESET});
        apb(1'b0, ba(CKPLL_IDX_REF_DIV), 8'h00);
        chk("ref reset value", rdat, 32'h00);
        apb(1'b0, ba(CKPLL_IDX_FB_DIV_HI), 8'h00);
        chk("fb reset value", rdat, 32'h00);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            chk("readback", rdat, {24'h0, rows[i].q});
            chk("slave error", rerr, rows[i].e);
        end
        // A mask-programmed part must ignore the strap.
        @(posedge clk_sys);
        rom_variant <= 1'b1;
        do_reset();
        apb(1'b0, ba(CKPLL_IDX_CLK_CTRL), 8'h00);
        chk("rom boot speed", rdat, 32'h00);
        speed(8'h00, 12, 2, 12);
        speed(8'h01, 24, 4, 12);
        speed(8'h47, 24, 4, 12);
        @(posedge clk_sys);
        idle_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tally(24);
        chk("idle cpu", c[0], 0);
        chk("idle per", c[1], 24);
        @(posedge clk_sys);
        power_down <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tally(24);
        chk("down per", c[1], 0);
        chk("down ref", c[6], 0);
        @(posedge clk_sys);
        idle_mode <= 1'b0;
        power_down <= 1'b0;
        apb(1'b1, ba(CKPLL_IDX_REF_DIV), 8'h03);
        apb(1'b1, ba(CKPLL_IDX_FB_DIV_HI), 8'h00);
        apb(1'b1, ba(CKPLL_IDX_IRQ_MASK), 8'h03);
        apb(1'b1, ba(CKPLL_IDX_SYN_CTRL), 8'hca);
        tally(60);
        chk("held audio", c[7], 0);
        chk("held lock", synth_lock_flag, 1'b0);
        apb(1'b1, ba(CKPLL_IDX_SYN_CTRL), 8'hc2);
        n = 0;
        do begin
            apb(1'b0, ba(CKPLL_IDX_SYN_CTRL), 8'h00);
            n++;
        end while (rdat[CKPLL_SY_LOCK] !== 1'b1 && n < 100);
        chk("lock bit", rdat, 32'hc3);
        chk("lock port", synth_lock_flag, 1'b1);
        chk("irq gain", irq, 1'b1);
        tally(24);
        chk("audio", c[7], 24);
        chk("usb", c[8], 24);
        apb(1'b1, ba(CKPLL_IDX_IRQ_STAT), 8'h01);
        chk("irq cleared", irq, 1'b0);
        apb(1'b1, ba(CKPLL_IDX_SYN_CTRL), 8'hc0);
        tally(24);
        chk("stop lock", synth_lock_flag, 1'b0);
        chk("stop audio", c[7], 0);
        apb(1'b0, ba(CKPLL_IDX_IRQ_STAT), 8'h00);
        chk("loss status", rdat, 32'h02);
        chk("irq loss", irq, 1'b1);
        apb(1'b1, ba(CKPLL_IDX_IRQ_MASK), 8'h00);
        chk("irq masked", irq, 1'b0);
        // A slower feedback path must drive the detector upward only.
        apb(1'b1, ba(CKPLL_IDX_FB_DIV_HI), 8'h01);
        apb(1'b1, ba(CKPLL_IDX_SYN_CTRL), 8'hc2);
        tally(200);
        chk("pump up seen", c[10] > 0, 1'b1);
        chk("pump down", c[11], 0);
        close_out();
    end
endmodule : test_clock_and_pll_control
